/* bsp_jtag_host.sv */
// model of the external boundary-scan controller driving the test port
module bsp_jtag_host #(
  parameter int LEN = 522
) (
  output logic           tck,
  output logic           tmsPin,
  output logic           tmsDrv,
  output logic           tdiPin,
  output logic           tdiDrv,
  input  wire logic      tdoOut,
  input  wire logic      tdoOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [LEN-1:0] lastOut = '0;
  event           scanDone;
  // test clock stands low between frames
  initial begin
    tck = 1'h0;
    tmsPin = 1'h1;
    tmsDrv = 1'h0;
    tdiPin = 1'h0;
    tdiDrv = 1'h0;
  end
  // lines change just after the fall; a released line shows no stale value
  task automatic tick(input logic m, input logic mDrv, input logic d, input logic dDrv,
                      output logic o);
    tmsDrv = mDrv;
    tmsPin = mDrv ? m : ~tmsPin;
    tdiDrv = dDrv;
    tdiPin = dDrv ? d : ~tdiPin;
    #15;
    o = (tdoOe === 1'h1) ? tdoOut : 1'hX;  // read only while enabled
    tck = 1'h1;
    #15;
    tck = 1'h0;
  endtask
  // five rises with mode select left to the pull-up, then to idle
  task automatic reset_tap();
    logic o;
    for (int i = 0; i < 5; i++) begin
      tick(1'h1, 1'h0, 1'h0, 1'h0, o);
    end
    tick(1'h0, 1'h1, 1'h0, 1'h0, o);
  endtask
  // no configuration phase exists here, so scans may run at any time
  task automatic scan(input logic ir, input logic [LEN-1:0] din, input logic dDrv = 1'h1);
    int   n;
    logic o;
    n = ir ? 3 : LEN;
    lastOut = '0;
    tick(1'h1, 1'h1, 1'h0, 1'h0, o);
    if (ir) begin
      tick(1'h1, 1'h1, 1'h0, 1'h0, o);
    end
    tick(1'h0, 1'h1, 1'h0, 1'h0, o);
    tick(1'h0, 1'h1, 1'h0, 1'h0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, 1'h1, din[i], dDrv, o);
      lastOut[i] = o;
    end
    tick(1'h1, 1'h1, 1'h0, 1'h0, o);
    tick(1'h0, 1'h1, 1'h0, 1'h0, o);
    -> scanDone;
    // watcher reads the result before a following scan clears it
    #1;
  endtask
endmodule

/* bsp_pkg.sv */
// shared constants and types for the boundary-scan test port
package bsp_pkg;

  localparam int IR_LEN = 3;
  localparam logic [IR_LEN-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 3'h5;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 3'h7;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;

  localparam int BSR_LEN_SMALL = 522;
  localparam int BSR_LEN_MID   = 621;
  localparam int BSR_LEN_LARGE = 666;

  localparam int SYNC_STAGES = 2;

  localparam logic PULL_LEVEL = 1'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;

  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } bsp_tap_state_t;

endpackage

/* bsp_sync.sv */
// multi-bit two-flop level synchroniser
module bsp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* bsp_tap_ctrl.sv */
// sixteen-state test access port controller
module bsp_tap_ctrl
  import bsp_pkg::*;
(
  input  wire logic  tck,
  input  wire logic  rstTck_n,
  input  wire logic  en,
  input  wire logic  tms,
  bsp_tap_if.ctrl    tap
);
  bsp_tap_state_t state_q;
  bsp_tap_state_t state_d;

  function automatic bsp_tap_state_t nextState(input bsp_tap_state_t s, input logic m);
    bsp_tap_state_t n;
    n = ST_RESET;
    unique case (s)
      ST_RESET:    n = m ? ST_RESET : ST_IDLE;
      ST_IDLE:     n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   n = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   n = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   n = m ? ST_SEL_DR : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction

  assign state_d = nextState(state_q, tms);

  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      state_q <= ST_RESET;
    end else if (en) begin
      state_q <= state_d;
    end
  end

  assign tap.tlr       = (state_q == ST_RESET);
  assign tap.captureDr = (state_q == ST_CAP_DR);
  assign tap.shiftDr   = (state_q == ST_SHIFT_DR);
  assign tap.updateDr  = (state_q == ST_UPD_DR);
  assign tap.captureIr = (state_q == ST_CAP_IR);
  assign tap.shiftIr   = (state_q == ST_SHIFT_IR);
  assign tap.updateIr  = (state_q == ST_UPD_IR);

  // five tms-high edges reach test-logic reset from anywhere
  a_tap_five_ones: assert property (@(posedge tck) disable iff (!rstTck_n)
    (en && tms) [*5] |=> (state_q == ST_RESET))
    else $error("tap not in reset after five tms-high edges");
endmodule

/* bsp_tap_if.sv */
// controller state decodes passed from the tap controller to the scan logic
interface bsp_tap_if;
  logic tlr;
  logic captureDr;
  logic shiftDr;
  logic updateDr;
  logic captureIr;
  logic shiftIr;
  logic updateIr;

  modport ctrl (output tlr, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr);
  modport user (input tlr, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr);
endinterface

/* bsp_top.sv */
// boundary-scan test port: instruction, bypass and boundary registers plus pin mux
// Overview of operation
// - instruction register is three bits; three bits shift per instruction scan.
// - sample/preload captures pin levels into boundary register; core keeps running.
// - sample/preload also loads update stages with a pattern for later test.
// - external test drives output pins from the update stages, not core logic.
// - external test captures input pin levels into the boundary register.
// - bypass puts one single-bit register between serial input and output.
// - bypass passes data through synchronously; normal operation continues.
// - boundary register length is a variant parameter: 522, 621 or 666 cells.
// - undriven test inputs read high through weak pull-ups.
module bsp_top
  import bsp_pkg::*;
#(
  parameter int BSR_LEN = bsp_pkg::BSR_LEN_SMALL
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               tck,
  input  wire logic               tmsPin,
  input  wire logic               tmsDrv,
  input  wire logic               tdiPin,
  input  wire logic               tdiDrv,
  output logic                    tdoOut,
  output logic                    tdoOe,
  input  wire logic [BSR_LEN-1:0] pinIn,
  input  wire logic [BSR_LEN-1:0] coreOut,
  output logic      [BSR_LEN-1:0] padOut,
  output logic                    testMode
);
  import bsp_pkg::*;

  // ---------------- test clock domain ----------------
  logic               rstMeta_q;
  logic               rstTck_n;
  logic               ceTck;
  logic               tms;
  logic               tdi;
  logic [BSR_LEN-1:0] pinTck;
  logic [IR_LEN-1:0]  irShift_q;
  logic [IR_LEN-1:0]  ir_q;
  logic               bypass_q;
  logic [BSR_LEN-1:0] bsrShift_q;
  logic [BSR_LEN-1:0] bsrUpd_q;
  logic               updTgl_q;
  logic               extestTck_q;
  logic               tdo_q;
  logic               tdoOe_q;
  logic               selBsr;
  logic               selExtest;
  logic               selBypass;
  logic               tdoMux;
  logic               inShift;

  bsp_tap_if tapIf ();

  function automatic logic usesBoundary(input logic [IR_LEN-1:0] op);
    return (op == OP_EXTEST) || (op == OP_SAMPLE);
  endfunction

  // reset asserts at once and releases on the test clock
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'h0;
      rstTck_n  <= 1'h0;
    end else begin
      rstMeta_q <= 1'h1;
      rstTck_n  <= rstMeta_q;
    end
  end

  bsp_sync #(.WIDTH(1)) u_ceSync (
    .clk   (tck),
    .rst_n (rstTck_n),
    .d     (ce),
    .q     (ceTck)
  );

  // pins are asynchronous to the test clock
  bsp_sync #(.WIDTH(BSR_LEN)) u_pinSync (
    .clk   (tck),
    .rst_n (rstTck_n),
    .d     (pinIn),
    .q     (pinTck)
  );

  // undriven inputs fall back to the pull-up level
  assign tms = tmsDrv ? tmsPin : PULL_LEVEL;
  assign tdi = tdiDrv ? tdiPin : PULL_LEVEL;

  bsp_tap_ctrl u_tap (
    .tck      (tck),
    .rstTck_n (rstTck_n),
    .en       (ceTck),
    .tms      (tms),
    .tap      (tapIf.ctrl)
  );

  assign selBsr    = usesBoundary(ir_q);
  assign selExtest = (ir_q == OP_EXTEST);
  assign selBypass = !usesBoundary(ir_q);
  assign inShift   = tapIf.shiftIr || tapIf.shiftDr;

  // instruction register, lsb shifts out first
  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      irShift_q <= IR_CAPTURE;
      ir_q      <= OP_BYPASS;
    end else if (ceTck) begin
      if (tapIf.tlr) begin
        ir_q <= OP_BYPASS;
      end else if (tapIf.updateIr) begin
        ir_q <= irShift_q;
      end
      if (tapIf.captureIr) begin
        irShift_q <= IR_CAPTURE;
      end else if (tapIf.shiftIr) begin
        irShift_q <= {tdi, irShift_q[IR_LEN-1:1]};
      end
    end
  end

  // single-stage bypass path
  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      bypass_q <= BYPASS_CAPTURE;
    end else if (ceTck && selBypass) begin
      if (tapIf.captureDr) begin
        bypass_q <= BYPASS_CAPTURE;
      end else if (tapIf.shiftDr) begin
        bypass_q <= tdi;
      end
    end
  end

  // boundary shift stages; capture the pad levels in both sample and extest
  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      bsrShift_q <= '0;
    end else if (ceTck && selBsr) begin
      if (tapIf.captureDr) begin
        bsrShift_q <= pinTck;
      end else if (tapIf.shiftDr) begin
        bsrShift_q <= {tdi, bsrShift_q[BSR_LEN-1:1]};
      end
    end
  end

  // update stages load under sample too, so a preload waits for extest
  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      bsrUpd_q <= '0;
      updTgl_q <= 1'h0;
    end else if (ceTck && selBsr && tapIf.updateDr) begin
      bsrUpd_q <= bsrShift_q;
      updTgl_q <= !updTgl_q;
    end
  end

  // loads on the update edge itself, since the test clock may stop right after it
  always_ff @(posedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      extestTck_q <= 1'h0;
    end else if (ceTck) begin
      if (tapIf.tlr) begin
        extestTck_q <= 1'h0;
      end else if (tapIf.updateIr) begin
        extestTck_q <= (irShift_q == OP_EXTEST);
      end
    end
  end

  assign tdoMux = tapIf.shiftIr ? irShift_q[0] : (selBsr ? bsrShift_q[0] : bypass_q);

  // output launched on the falling edge gives the far end half a period of setup
  always_ff @(negedge tck or negedge rstTck_n) begin
    if (!rstTck_n) begin
      tdo_q   <= 1'h0;
      tdoOe_q <= 1'h0;
    end else if (ceTck) begin
      tdo_q   <= tdoMux;
      tdoOe_q <= inShift;
    end
  end

  assign tdoOut = tdo_q;
  assign tdoOe  = tdoOe_q;

  // ---------------- core clock domain ----------------
  logic               extestCore;
  logic               tglCore;
  logic               tglSeen_q;
  logic               tglPend;
  logic [BSR_LEN-1:0] updCore_q;
  logic [BSR_LEN-1:0] padOut_q;
  logic [BSR_LEN-1:0] padSel;

  bsp_sync #(.WIDTH(1)) u_extestSync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (extestTck_q),
    .q     (extestCore)
  );

  bsp_sync #(.WIDTH(1)) u_tglSync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .d     (updTgl_q),
    .q     (tglCore)
  );

  assign tglPend = (tglCore != tglSeen_q);

  // update word is stable for several test clocks after each toggle,
  // far longer than the three core cycles the toggle needs to land
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tglSeen_q <= 1'h0;
      updCore_q <= '0;
    end else if (ce && tglPend) begin
      tglSeen_q <= tglCore;
      updCore_q <= bsrUpd_q;
    end
  end

  assign padSel = extestCore ? updCore_q : coreOut;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      padOut_q <= '0;
    end else if (ce) begin
      padOut_q <= padSel;
    end
  end

  assign padOut   = padOut_q;
  assign testMode = extestCore;

  // ---------------- checks ----------------
  a_ir_reset_bypass: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.tlr) |=> (ir_q == OP_BYPASS))
    else $error("bypass not selected after test-logic reset");

  a_ir_three_shift: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.shiftIr) [*3] |=> (irShift_q[IR_LEN-1] == $past(tdi)) &&
      (irShift_q[0] == $past(tdi, 3)))
    else $error("instruction bits did not take three shifts");

  a_ir_update_load: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.updateIr) |=> (ir_q == $past(irShift_q)))
    else $error("instruction not loaded on update");

  a_bypass_path: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.shiftDr && selBypass) |=> (bypass_q == $past(tdi)))
    else $error("bypass stage did not take serial input");

  a_bypass_decode: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ir_q != OP_EXTEST && ir_q != OP_SAMPLE) |->
      (selBypass && !selBsr && (tapIf.shiftIr || (tdoMux == bypass_q))))
    else $error("unassigned code did not select bypass");

  a_bsr_capture_pins: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.captureDr && selBsr) |=> (bsrShift_q == $past(pinTck)))
    else $error("pin levels not captured into boundary register");

  a_bsr_shift_len: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.shiftDr && selBsr) |=>
      (bsrShift_q[BSR_LEN-1] == $past(tdi)) && (bsrShift_q[BSR_LEN-2] == $past(bsrShift_q[BSR_LEN-1])))
    else $error("boundary register did not shift one cell");

  a_upd_preload: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.updateDr && selBsr) |=> (bsrUpd_q == $past(bsrShift_q)) &&
      (updTgl_q != $past(updTgl_q)))
    else $error("update stages not loaded");

  a_tdo_enable: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && $past(ceTck)) |-> (tdoOe_q == inShift))
    else $error("serial output enable outside shift states");

  a_pad_extest: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && extestCore && !tglPend) |=> (padOut == $past(updCore_q)))
    else $error("pins not driven from update stages under extest");

  a_pad_functional: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ce && !extestCore) |=> (padOut == $past(coreOut)))
    else $error("core output not passed to pins outside extest");

  a_pad_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!ce) |=> $stable(padOut))
    else $error("pins changed while clock enable low");

  a_ir_capture_value: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.captureIr) |=> (irShift_q == IR_CAPTURE))
    else $error("instruction capture value wrong");

  a_bypass_capture: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.captureDr && selBypass) |=> (bypass_q == BYPASS_CAPTURE))
    else $error("bypass stage did not capture zero");

  a_extest_track: assert property (@(posedge tck) disable iff (!rstTck_n)
    (extestTck_q == selExtest))
    else $error("test mode flag out of step with instruction");

  a_extest_clear: assert property (@(posedge tck) disable iff (!rstTck_n)
    (ceTck && tapIf.tlr) |=> !extestTck_q)
    else $error("test mode left on after test-logic reset");
endmodule

/* bsp_top_test.sv */
// self-checking bench for the boundary-scan test port
module bsp_top_test import bsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LEN = BSR_LEN_MID;
  typedef struct {
    string          name;
    logic [LEN-1:0] v;
  } bsp_note_t;
  logic           core_clk = 1'h0;
  logic           rst_n    = 1'h0;
  logic           ce       = 1'h1;
  logic           tck;
  logic           tmsPin;
  logic           tmsDrv;
  logic           tdiPin;
  logic           tdiDrv;
  logic           tdoOut;
  logic           tdoOe;
  logic [LEN-1:0] pinIn    = '0;
  logic [LEN-1:0] coreOut  = '0;
  logic [LEN-1:0] padOut;
  logic           testMode;
  bsp_note_t      expQ[$];
  bsp_note_t      cur;
  int             seed     = 78;
  int             failures = 0;
  int             testsRun = 0;
  always #5 core_clk = ~core_clk;
  bsp_top #(.BSR_LEN(LEN)) i_bsp_top (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .tck(tck),
    .tmsPin(tmsPin), .tmsDrv(tmsDrv), .tdiPin(tdiPin), .tdiDrv(tdiDrv),
    .tdoOut(tdoOut), .tdoOe(tdoOe), .pinIn(pinIn), .coreOut(coreOut),
    .padOut(padOut), .testMode(testMode)
  );
  bsp_jtag_host #(.LEN(LEN)) i_bsp_jtag_host (
    .tck(tck), .tmsPin(tmsPin), .tmsDrv(tmsDrv), .tdiPin(tdiPin),
    .tdiDrv(tdiDrv), .tdoOut(tdoOut), .tdoOe(tdoOe)
  );
  task automatic stop_test();
    if (failures == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [LEN-1:0] exp, input logic [LEN-1:0] got);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic note(input string what, input logic [LEN-1:0] v);
    expQ.push_back('{what, v});
  endtask
  // oldest note is matched against each finished scan
  always @(i_bsp_jtag_host.scanDone) begin
    if (expQ.size() == 0) begin
      failures++;
      $display("BAD scan expected none seen %0h", i_bsp_jtag_host.lastOut);
    end else begin
      cur = expQ.pop_front();
      check(cur.name, cur.v, i_bsp_jtag_host.lastOut);
    end
  end
  function automatic logic [LEN-1:0] rnd_vec();
    logic [LEN-1:0] r;
    r = '0;
    for (int i = 0; i < LEN; i += 32) begin
      r = (r << 32) | LEN'($unsigned($random(seed)));
    end
    return r;
  endfunction
  // pad crossing takes a few core cycles, so poll under a bound
  task automatic wait_pad(input logic [LEN-1:0] exp);
    int k;
    k = 0;
    while (padOut !== exp && k < 20) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check("padOut", exp, padOut);
    if (padOut !== exp) begin
      stop_test();
    end
  endtask
  task automatic ir_load(input logic [2:0] code);
    note("irCapture", LEN'(IR_CAPTURE));
    i_bsp_jtag_host.scan(1'h1, LEN'(code));
  endtask
  task automatic bypass_scan(input string what);
    logic [LEN-1:0] p;
    p = rnd_vec();
    note(what, {p[LEN-2:0], 1'h0});
    i_bsp_jtag_host.scan(1'h0, p);
  endtask
  initial begin
    logic [LEN-1:0] pat;
    // reset spans test clocks too, since the link side clears on them
    i_bsp_jtag_host.reset_tap();
    @(posedge core_clk);
    rst_n <= 1'h1;
    i_bsp_jtag_host.reset_tap();
    bypass_scan("bypassReset");
    @(posedge core_clk);
    pat = rnd_vec();
    coreOut <= pat;
    pinIn <= rnd_vec();
    wait_pad(pat);
    check_bit("testMode", 1'h0, testMode);
    @(posedge core_clk);
    ce <= 1'h0;
    coreOut <= rnd_vec();
    repeat (6) @(posedge core_clk);
    #1;
    check("padFrozen", pat, padOut);  // clock enable low
    @(posedge core_clk);
    ce <= 1'h1;
    wait_pad(coreOut);
    for (int c = 0; c < 8; c++) begin
      ir_load(3'(c));
      if (3'(c) != OP_EXTEST && 3'(c) != OP_SAMPLE) begin
        bypass_scan("bypassCode");
      end
    end
    ir_load(OP_SAMPLE);
    pat = rnd_vec();
    note("sample", pinIn);
    i_bsp_jtag_host.scan(1'h0, pat);
    repeat (8) @(posedge core_clk);
    #1;
    check("padOut", coreOut, padOut);
    ir_load(OP_EXTEST);
    wait_pad(pat);
    check_bit("testMode", 1'h1, testMode);
    @(posedge core_clk);
    pinIn <= rnd_vec();
    repeat (2) @(posedge core_clk);
    pat = rnd_vec();
    note("extest", pinIn);
    i_bsp_jtag_host.scan(1'h0, pat);
    wait_pad(pat);
    i_bsp_jtag_host.reset_tap();
    wait_pad(coreOut);
    check_bit("testMode", 1'h0, testMode);
    bypass_scan("bypassPullup");
    note("tdiPullup", {{(LEN - 1){1'h1}}, 1'h0});
    i_bsp_jtag_host.scan(1'h0, '0, 1'h0);
    #1;
    check_bit("queueEmpty", 1'h1, expQ.size() == 0);  // every result seen
    stop_test();
  end
endmodule
